// ===== pkg/udf_pkg.sv
/*
 * Shared constants and types for the data-flow command interpreter of a
 * full-speed USB device controller.
 * Assumes one 100 MHz clock and a synchronous active-high reset.
 */
package udf_pkg;

    // Command codes and masks on the 8-bit command bus.
    localparam logic [7:0] CMD_READ_IRQ = 8'hf4;
    localparam logic [7:0] CMD_READ_BUF = 8'hf0;
    localparam logic [7:0] CMD_SEL_BASE = 8'h00;
    localparam logic [7:0] CMD_TXS_BASE = 8'h40;
    localparam logic [7:0] CMD_BUFS_BASE = 8'h80;
    localparam logic [7:0] CMD_GROUP_MASK = 8'hf0;
    localparam logic [3:0] EP_MAX_DEFAULT = 4'h5;
    localparam logic [3:0] EP_MAX_EXT = 4'hf;
    localparam logic [2:0] IRQ_BYTES_DEFAULT = 3'h2;
    localparam logic [2:0] IRQ_BYTES_EXT = 3'h4;
    localparam int NUM_EP = 16;

    // Field positions inside the returned bytes.
    localparam int IRQ1_BUS_RESET_BIT = 6;
    localparam int IRQ1_SUSPEND_BIT = 7;
    localparam int IRQ2_DMA_DONE_BIT = 0;
    localparam int SEL_FULL_BIT = 0;
    localparam int SEL_STALL_BIT = 1;
    localparam int TXS_OK_BIT = 0;
    localparam int TXS_ERR_LSB = 1;
    localparam int TXS_SETUP_BIT = 5;
    localparam int TXS_TOGGLE_BIT = 6;
    localparam int TXS_OVERRUN_BIT = 7;
    localparam int BUFS_SETUP_BIT = 2;
    localparam int BUFS_FULL0_BIT = 5;
    localparam int BUFS_FULL1_BIT = 6;
    localparam int BUFS_STALL_BIT = 7;

    // Reset values.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // Transaction error codes.
    typedef enum logic [3:0] {
        ERR_NONE = 4'h0, ERR_PID_ENC = 4'h1, ERR_PID_UNK = 4'h2,
        ERR_UNEXP_PKT = 4'h3, ERR_TOKEN_CRC = 4'h4, ERR_DATA_CRC = 4'h5,
        ERR_TIMEOUT = 4'h6, ERR_RSVD = 4'h7, ERR_UNEXP_EOP = 4'h8,
        ERR_NAKED = 4'h9, ERR_SENT_STALL = 4'ha, ERR_OVERFLOW = 4'hb,
        ERR_BIT_STUFF = 4'hd, ERR_DATA_PID = 4'hf
    } udf_err_e;

    // Result of one USB transaction reported by the serial engine.
    typedef struct packed {
        logic ok;
        udf_err_e err;
        logic setup;
        logic toggle;
    } udf_txn_s;

    // Which byte sequence the next read strobe returns.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01, ST_IRQ = 8'h02, ST_SEL = 8'h04, ST_TXS = 8'h08,
        ST_BUFS = 8'h10, ST_LEN_HI = 8'h20, ST_LEN_LO = 8'h40, ST_DATA = 8'h80
    } udf_state_e;

endpackage

// ===== design/udf_dataflow_cmds.sv
/*
 * Data-flow command interpreter and its OUT payload FIFO.
 * Assumes commands and read strobes are synchronous one-cycle pulses and
 * that the serial engine reports endpoint events and buffer state.
 */
`timescale 1ns/1ns

// Payload FIFO; full and valid are registered so the ports come from flops.
module udf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,               // Clock.
    input wire logic srst_in,              // Synchronous reset.
    input wire logic in_valid_in,          // Write request.
    input wire logic [WIDTH-1:0] in_data_in, // Write data.
    output logic in_ready_out,             // Room available.
    output logic out_valid_out,            // Data available.
    output logic [WIDTH-1:0] out_data_out, // Head word.
    input wire logic out_ready_in          // Pop request.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // Transfers happen only when both sides agree.
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data_out = mem[rd_ptr];

    // Storage is written without reset; only pointers, fill level and flags need defined values.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers, fill level and the registered flags move together.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready_out <= (next_count != (AW + 1)'(DEPTH));
            out_valid_out <= (next_count != '0);
        end
    end
endmodule

module udf_dataflow_cmds #(
    parameter int FIFO_DEPTH = 32,
    parameter int FIFO_WIDTH = 8
) (
    input wire logic ref_clk_in,              // 100 MHz clock.
    input wire logic srst_in,                 // Synchronous reset, high.
    input wire logic ext_mode_in,             // Extended command set active.
    input wire logic cmd_wr_in,               // Command byte strobe.
    input wire logic [7:0] cmd_in,            // Command byte.
    input wire logic rd_req_in,               // Data read strobe.
    output logic [7:0] rd_data_out,           // Returned byte.
    output logic rd_valid_out,                // Returned byte valid pulse.
    output logic [3:0] cur_ep_out,            // Currently selected endpoint.
    input wire logic txn_evt_in,              // Transaction finished pulse.
    input wire logic [3:0] txn_ep_in,         // Endpoint index of it.
    input udf_pkg::udf_txn_s txn_in,          // Its result.
    input wire logic bus_reset_in,            // USB bus reset seen pulse.
    input wire logic suspend_chg_in,          // Suspend entered or left pulse.
    input wire logic dma_done_in,             // DMA transfer finished pulse.
    input wire logic [15:0] ep_full_in,       // Buffer 0 full per endpoint.
    input wire logic [15:0] ep_full1_in,      // Buffer 1 full per endpoint.
    input wire logic [15:0] ep_stall_in,      // Stalled per endpoint.
    input wire logic [15:0] ep_setup_in,      // Setup packet held per endpoint.
    input wire logic dma_mode_in,             // Buffer drained by DMA.
    input wire logic dma_rd_req_in,           // DMA read strobe.
    output logic [7:0] dma_data_out,          // DMA payload byte.
    output logic dma_valid_out,               // DMA byte valid pulse.
    input wire logic pay_valid_in,            // Payload byte offered.
    input wire logic [FIFO_WIDTH-1:0] pay_data_in, // Payload byte.
    input wire logic [9:0] pay_len_in,        // Length of packet in buffer.
    output logic pay_ready_out                // Payload FIFO has room.
);
    import udf_pkg::*;

    udf_state_e state;
    logic [2:0] irq_idx;
    logic [3:0] cmd_ep;
    logic [9:0] len;
    logic [15:0] ep_irq;
    logic bus_reset_flag;
    logic suspend_flag;
    logic dma_done_flag;
    udf_txn_s txn_mem [NUM_EP];
    logic [15:0] unread;
    logic [15:0] overrun;
    logic [7:0] next_byte;
    logic [7:0] irq_b1;
    logic [7:0] irq_b2;
    logic [7:0] irq_b3;
    logic [7:0] irq_b4;
    logic [2:0] irq_limit;
    logic rd_irq0;
    logic rd_irq1;
    logic rd_txs;
    logic fifo_valid;
    logic [FIFO_WIDTH-1:0] fifo_data;
    logic fifo_pop;

    // An index outside the active mode's range is not executed; the command only returns the sequence to idle.
    function automatic logic ep_ok(input logic [3:0] idx, input logic ext);
        ep_ok = idx <= (ext ? EP_MAX_EXT : EP_MAX_DEFAULT);
    endfunction

    // Read side effects are taken at the strobe that returns the byte.
    assign rd_irq0 = rd_req_in && !cmd_wr_in && state == ST_IRQ && irq_idx == 3'h0;
    assign rd_irq1 = rd_req_in && !cmd_wr_in && state == ST_IRQ && irq_idx == 3'h1;
    assign rd_txs = rd_req_in && !cmd_wr_in && state == ST_TXS;
    assign irq_limit = ext_mode_in ? IRQ_BYTES_EXT : IRQ_BYTES_DEFAULT;

    // Pack the flag bytes; reserved bits read as zero.
    assign irq_b1 = {suspend_flag, bus_reset_flag, ep_irq[5:0]};
    assign irq_b2 = {7'h00, dma_done_flag};
    assign irq_b3 = ep_irq[13:6];
    assign irq_b4 = {6'h00, ep_irq[15:14]};

    // Payload leaves the FIFO to the port or to DMA, never to both.
    assign fifo_pop = dma_mode_in ? dma_rd_req_in
                                  : (rd_req_in && !cmd_wr_in && state == ST_DATA);

    udf_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .srst_in(srst_in),
        .in_valid_in(pay_valid_in),
        .in_data_in(pay_data_in),
        .in_ready_out(pay_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(fifo_pop)
    );

    // Byte returned by the next read strobe in the current sequence.
    always_comb begin
        next_byte = BYTE_RESET;
        case (state)
            ST_IRQ: begin
                if (irq_idx < irq_limit) begin
                    case (irq_idx)
                        3'h0: next_byte = irq_b1;
                        3'h1: next_byte = irq_b2;
                        3'h2: next_byte = irq_b3;
                        3'h3: next_byte = irq_b4;
                        default: next_byte = BYTE_RESET;
                    endcase
                end
            end
            ST_SEL: begin
                next_byte[SEL_FULL_BIT] = ep_full_in[cur_ep_out];
                next_byte[SEL_STALL_BIT] = ep_stall_in[cur_ep_out];
            end
            ST_TXS: begin
                next_byte[TXS_OK_BIT] = txn_mem[cmd_ep].ok;
                next_byte[TXS_ERR_LSB +: 4] = txn_mem[cmd_ep].err;
                next_byte[TXS_SETUP_BIT] = txn_mem[cmd_ep].setup;
                next_byte[TXS_TOGGLE_BIT] = txn_mem[cmd_ep].toggle;
                next_byte[TXS_OVERRUN_BIT] = overrun[cmd_ep];
            end
            ST_BUFS: begin
                next_byte[BUFS_SETUP_BIT] = ep_setup_in[cmd_ep];
                next_byte[BUFS_FULL0_BIT] = ep_full_in[cmd_ep];
                next_byte[BUFS_FULL1_BIT] = ep_full1_in[cmd_ep];
                next_byte[BUFS_STALL_BIT] = ep_stall_in[cmd_ep];
            end
            ST_LEN_HI: next_byte = {6'h00, len[9:8]};
            ST_LEN_LO: next_byte = len[7:0];
            ST_DATA: next_byte = fifo_valid ? fifo_data : BYTE_RESET;
            default: next_byte = BYTE_RESET;
        endcase
    end

    // Command decode and byte sequencing; a new command aborts the old one.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state <= ST_IDLE;
            irq_idx <= 3'h0;
            cmd_ep <= 4'h0;
            cur_ep_out <= 4'h0;
            len <= 10'h000;
        end else if (cmd_wr_in) begin
            irq_idx <= 3'h0;
            if (cmd_in == CMD_READ_IRQ) begin
                state <= ST_IRQ;
            end else if (cmd_in == CMD_READ_BUF) begin
                state <= dma_mode_in ? ST_IDLE : ST_LEN_HI;
                len <= pay_len_in;
            end else if ((cmd_in & CMD_GROUP_MASK) == CMD_SEL_BASE
                         && ep_ok(cmd_in[3:0], ext_mode_in)) begin
                state <= ST_SEL;
                cur_ep_out <= cmd_in[3:0];
            end else if ((cmd_in & CMD_GROUP_MASK) == CMD_TXS_BASE
                         && ep_ok(cmd_in[3:0], ext_mode_in)) begin
                state <= ST_TXS;
                cmd_ep <= cmd_in[3:0];
            end else if ((cmd_in & CMD_GROUP_MASK) == CMD_BUFS_BASE
                         && ep_ok(cmd_in[3:0], ext_mode_in)) begin
                state <= ST_BUFS;
                cmd_ep <= cmd_in[3:0];
            end else begin
                state <= ST_IDLE;
            end
        end else if (rd_req_in) begin
            case (state)
                ST_IRQ: irq_idx <= (irq_idx == 3'h7) ? irq_idx : irq_idx + 3'h1;
                ST_SEL: state <= ST_IDLE;
                ST_TXS: state <= ST_IDLE;
                ST_BUFS: state <= ST_IDLE;
                ST_LEN_HI: state <= ST_LEN_LO;
                ST_LEN_LO: state <= ST_DATA;
                ST_DATA: state <= ST_DATA;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Returned byte; strobes with no sequence open still answer with zero.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rd_data_out <= BYTE_RESET;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_req_in && !cmd_wr_in;
            if (rd_req_in && !cmd_wr_in) begin
                rd_data_out <= next_byte;
            end
        end
    end

    // DMA sees payload only; the length bytes are never queued for it.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            dma_data_out <= BYTE_RESET;
            dma_valid_out <= 1'b0;
        end else begin
            dma_valid_out <= dma_mode_in && dma_rd_req_in && fifo_valid;
            if (dma_mode_in && dma_rd_req_in && fifo_valid) begin
                dma_data_out <= fifo_data;
            end
        end
    end

    // Read-clear flags; an event in the clearing cycle wins over the clear.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            bus_reset_flag <= 1'b0;
            suspend_flag <= 1'b0;
            dma_done_flag <= 1'b0;
        end else begin
            bus_reset_flag <= bus_reset_in || (bus_reset_flag && !rd_irq0);
            suspend_flag <= suspend_chg_in || (suspend_flag && !rd_irq0);
            dma_done_flag <= dma_done_in || (dma_done_flag && !rd_irq1);
        end
    end

    // Per-endpoint flags, cleared only by reading that endpoint's status.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ep_irq <= FLAGS_RESET;
            unread <= FLAGS_RESET;
            overrun <= FLAGS_RESET;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (txn_evt_in && txn_ep_in == 4'(i)) begin
                    ep_irq[i] <= 1'b1;
                    unread[i] <= 1'b1;
                    overrun[i] <= unread[i] && !(rd_txs && cmd_ep == 4'(i));
                end else if (rd_txs && cmd_ep == 4'(i)) begin
                    ep_irq[i] <= 1'b0;
                    unread[i] <= 1'b0;
                    overrun[i] <= 1'b0;
                end
            end
        end
    end

    // Last transaction result per endpoint; reset clears every entry to zero.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < NUM_EP; i++) begin
                txn_mem[i] <= '0;
            end
        end else if (txn_evt_in) begin
            txn_mem[txn_ep_in] <= txn_in;
        end
    end

    a_txn_sets_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        txn_evt_in |=> ep_irq[$past(txn_ep_in)])
        else $error("endpoint flag not set by transaction");
    a_bus_reset_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        rd_irq0 && bus_reset_flag
        |=> rd_valid_out && rd_data_out[IRQ1_BUS_RESET_BIT])
        else $error("bus reset flag not reported");
    a_bus_reset_clr: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        rd_irq0 && !bus_reset_in |=> !bus_reset_flag)
        else $error("bus reset flag not cleared by read");
    a_suspend_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        suspend_chg_in |=> suspend_flag)
        else $error("suspend change lost");
    a_dma_done_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        dma_done_in |=> dma_done_flag ##0 irq_b2 == 8'h01)
        else $error("dma done flag wrong");
    a_irq_beyond: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        rd_req_in && !cmd_wr_in && state == ST_IRQ && irq_idx >= irq_limit
        |=> rd_data_out == 8'h00)
        else $error("extra interrupt byte not zero");
    a_select_ep: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        cmd_wr_in && cmd_in[7:4] == 4'h0 && ep_ok(cmd_in[3:0], ext_mode_in)
        |=> cur_ep_out == $past(cmd_in[3:0]) && state == ST_SEL)
        else $error("endpoint not selected");
    a_overrun_set: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        txn_evt_in && unread[txn_ep_in] && !rd_txs |=> overrun[$past(txn_ep_in)])
        else $error("overwritten status not flagged");
    a_len_first: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        cmd_wr_in && cmd_in == CMD_READ_BUF && !dma_mode_in ##1 !cmd_wr_in && !rd_req_in
        ##1 rd_req_in && !cmd_wr_in |=> rd_data_out == 8'($past(pay_len_in, 3) >> 8))
        else $error("length high byte not first");

    c_irq_ext: cover property (@(posedge ref_clk_in) disable iff (srst_in)
        ext_mode_in && state == ST_IRQ && irq_idx == 3'h3 && rd_req_in);
    c_txs_overrun: cover property (@(posedge ref_clk_in) disable iff (srst_in)
        rd_txs && overrun[cmd_ep]);
    c_buf_payload: cover property (@(posedge ref_clk_in) disable iff (srst_in)
        state == ST_DATA && rd_req_in && fifo_valid);
    c_dma_byte: cover property (@(posedge ref_clk_in) disable iff (srst_in)
        dma_valid_out);
endmodule

// ===== verif/udf_mcu_model.sv
/*
 * Model of the external processor on the 8-bit command bus: it issues
 * commands and read strobes and collects the returned bytes.
 * Assumes one shared clock and the block's one-cycle read answer.
 */
`timescale 1ns/1ns

module udf_mcu_model (
    input wire logic clk_in,           // Bus clock.
    input wire logic [7:0] rd_data_in, // Returned byte.
    input wire logic rd_valid_in,      // Returned byte valid.
    output logic cmd_wr_out,           // Command strobe.
    output logic [7:0] cmd_out,        // Command byte.
    output logic rd_req_out            // Read strobe.
);
    import udf_pkg::*;

    localparam logic [7:0] CLEAR_BUF = 8'hf2;

    // The bus starts idle with a code that no command decodes to.
    initial begin
        cmd_wr_out = 1'b0;
        cmd_out = 8'hff;
        rd_req_out = 1'b0;
    end

    // One-cycle command pulse; the code is inverted once released, so a stale value is no help.
    task automatic put_cmd(input logic [7:0] c);
        @(posedge clk_in);
        cmd_wr_out <= 1'b1;
        cmd_out <= c;
        @(posedge clk_in);
        cmd_wr_out <= 1'b0;
        cmd_out <= ~c;
        #1;
    endtask

    // Read strobe, then a bounded wait for the answer pulse.
    task automatic get_byte(output logic [7:0] b, output bit ok);
        ok = 1'b0;
        b = 8'h00;
        @(posedge clk_in);
        rd_req_out <= 1'b1;
        @(posedge clk_in);
        rd_req_out <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid_in === 1'b1) begin
                b = rd_data_in;
                ok = 1'b1;
            end else begin
                @(posedge clk_in);
            end
        end
    endtask

    // Issues the clear-buffer code 8'hf2; the block decodes no such command and only returns to idle.
    task automatic clear_buffer();
        put_cmd(CLEAR_BUF);
    endtask
endmodule

// ===== verif/udf_dataflow_cmds_test.sv
/*
 * Self-checking testbench of the data-flow command interpreter.
 * Assumes the processor model in udf_mcu_model and the shared package.
 */
`timescale 1ns/1ns

module udf_dataflow_cmds_test;
    import udf_pkg::*;

    logic clk, srst, ext, txn_evt, bus_rst, susp, dma_done, dma_mode, dma_rd, pay_valid;
    logic rd_valid, dma_valid, pay_ready, cmd_wr, rd_req;
    logic [3:0] txn_ep, cur_ep;
    logic [15:0] full0, full1, stall, setup;
    logic [7:0] pay_data, rd_data, dma_data, cmd;
    logic [9:0] pay_len;
    udf_txn_s txn;
    int failures, num_checks;

    udf_dataflow_cmds #(.FIFO_DEPTH(32), .FIFO_WIDTH(8)) dut (
        .ref_clk_in(clk), .srst_in(srst), .ext_mode_in(ext), .cmd_wr_in(cmd_wr),
        .cmd_in(cmd), .rd_req_in(rd_req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .cur_ep_out(cur_ep), .txn_evt_in(txn_evt), .txn_ep_in(txn_ep), .txn_in(txn),
        .bus_reset_in(bus_rst), .suspend_chg_in(susp), .dma_done_in(dma_done),
        .ep_full_in(full0), .ep_full1_in(full1), .ep_stall_in(stall), .ep_setup_in(setup),
        .dma_mode_in(dma_mode), .dma_rd_req_in(dma_rd), .dma_data_out(dma_data),
        .dma_valid_out(dma_valid), .pay_valid_in(pay_valid), .pay_data_in(pay_data),
        .pay_len_in(pay_len), .pay_ready_out(pay_ready));

    udf_mcu_model mcu (.clk_in(clk), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .cmd_wr_out(cmd_wr), .cmd_out(cmd), .rd_req_out(rd_req));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compares one byte, counting every comparison made.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reads one byte through the model; a missing answer ends the run.
    task automatic rd(input logic [7:0] exp);
        logic [7:0] b;
        bit ok;
        mcu.get_byte(b, ok);
        if (!ok) begin
            failures++;
            conclude();
        end
        chk(b, exp);
    endtask

    // One finished transaction reported by the serial engine.
    task automatic evt(input logic [3:0] ep, input logic ok, input udf_err_e e,
                       input logic s, input logic t);
        @(posedge clk);
        txn_ep <= ep;
        txn <= '{ok, e, s, t};
        txn_evt <= 1'b1;
        @(posedge clk);
        txn_evt <= 1'b0;
    endtask

    // Offers up to n bytes; returns how many the FIFO took before refusing.
    task automatic fill(input int n, output int k);
        k = 0;
        @(posedge clk);
        pay_data <= 8'h00;
        pay_valid <= 1'b1;
        while (k < n) begin
            #1;
            if (pay_ready !== 1'b1) break;
            @(posedge clk);
            k++;
            pay_data <= 8'(k);
        end
        if (k < n) @(posedge clk);
        pay_valid <= 1'b0;
    endtask

    // Changes the command set and the drain path between transfers.
    task automatic set_mode(input logic e, input logic d);
        @(posedge clk);
        ext <= e;
        dma_mode <= d;
    endtask

    // Pulses the bus reset, suspend change and DMA done events as chosen.
    task automatic pulse_flags(input logic [2:0] m);
        @(posedge clk);
        {bus_rst, susp, dma_done} <= m;
        @(posedge clk);
        {bus_rst, susp, dma_done} <= 3'b000;
    endtask

    // Flag bytes in default mode, set and read-clear behaviour.
    task automatic t_irq();
        mcu.put_cmd(CMD_READ_IRQ);
        rd(8'h00);
        rd(8'h00);
        rd(8'h00);
        evt(4'h1, 1'b1, ERR_NONE, 1'b0, 1'b1);
        pulse_flags(3'b111);
        mcu.put_cmd(CMD_READ_IRQ);
        rd(8'hc2);
        rd(8'h01);
        rd(8'h00);
        mcu.put_cmd(CMD_READ_IRQ);
        rd(8'h02);
        rd(8'h00);
    endtask

    logic [7:0] exp_ext[5] = '{8'h02, 8'h00, 8'h04, 8'h02, 8'h00};

    // Extended flag bytes, and clearing through the status commands.
    task automatic t_ext();
        set_mode(1'b1, 1'b0);
        evt(4'h8, 1'b1, ERR_NONE, 1'b1, 1'b0);
        evt(4'hf, 1'b0, ERR_DATA_PID, 1'b0, 1'b1);
        mcu.put_cmd(CMD_READ_IRQ);
        foreach (exp_ext[i]) rd(exp_ext[i]);
        mcu.put_cmd(8'h41);
        rd(8'h41);
        mcu.put_cmd(8'h48);
        rd(8'h21);
        mcu.put_cmd(8'h4f);
        rd(8'h5e);
        mcu.put_cmd(CMD_READ_IRQ);
        repeat (4) rd(8'h00);
        set_mode(1'b0, 1'b0);
    endtask

    // Every error code once, then an overwritten unread status.
    task automatic t_codes();
        udf_err_e e;
        e = e.first();
        repeat (e.num()) begin
            evt(4'h2, 1'b0, e, 1'b0, 1'b0);
            mcu.put_cmd(8'h42);
            rd({3'h0, e, 1'b0});
            e = e.next();
        end
        evt(4'h2, 1'b1, ERR_NONE, 1'b0, 1'b0);
        evt(4'h2, 1'b0, ERR_TIMEOUT, 1'b0, 1'b0);
        mcu.put_cmd(8'h42);
        rd(8'h8c);
        evt(4'h2, 1'b0, ERR_TIMEOUT, 1'b0, 1'b0);
        mcu.put_cmd(8'h42);
        rd(8'h0c);
    endtask

    // Endpoint selection, its status byte and the buffer status byte.
    task automatic t_sel();
        logic [15:0] m;
        m = 16'h0008;
        @(posedge clk);
        full0 <= m;
        stall <= m;
        setup <= m;
        full1 <= m << 11;
        mcu.put_cmd(8'h03);
        chk({4'h0, cur_ep}, 8'h03);
        rd(8'h03);
        rd(8'h00);
        mcu.put_cmd(8'h06);
        chk({4'h0, cur_ep}, 8'h03);
        rd(8'h00);
        mcu.put_cmd(8'h83);
        rd(8'ha4);
        mcu.put_cmd(8'h86);
        rd(8'h00);
        set_mode(1'b1, 1'b0);
        mcu.put_cmd(8'h0e);
        chk({4'h0, cur_ep}, 8'h0e);
        rd(8'h00);
        mcu.put_cmd(8'h8e);
        rd(8'h40);
        set_mode(1'b0, 1'b0);
    endtask

    // A reset in mid-run drops every pending flag and the selection.
    task automatic t_rst();
        evt(4'h0, 1'b1, ERR_NONE, 1'b0, 1'b0);
        pulse_flags(3'b110);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({cur_ep, rd_valid, dma_valid, pay_ready, 1'b0}, 8'h02);
        mcu.put_cmd(CMD_READ_IRQ);
        rd(8'h00);
        rd(8'h00);
    endtask

    // Fills the FIFO until it refuses, then streams it out with its length.
    task automatic t_buf();
        int k;
        fill(40, k);
        chk(8'(k), 8'h20);
        pay_len <= 10'h103 + 10'(k);
        mcu.put_cmd(CMD_READ_BUF);
        rd(8'h01);
        rd(8'h23);
        for (int i = 0; i < 32; i++) rd(8'(i));
        rd(8'h00);
        chk({7'h0, pay_ready}, 8'h01);
        mcu.clear_buffer();
    endtask

    // DMA drain returns payload only, with no length bytes.
    task automatic t_dma();
        int k;
        bit got;
        set_mode(1'b0, 1'b1);
        fill(3, k);
        mcu.put_cmd(CMD_READ_BUF);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            dma_rd <= 1'b1;
            @(posedge clk);
            dma_rd <= 1'b0;
            #1;
            got = (dma_valid === 1'b1);
            chk({7'h0, got}, 8'h01);
            chk(dma_data, 8'(i));
        end
        set_mode(1'b0, 1'b0);
    endtask

    // Main sequence: reset for 12 cycles, then the scenarios in turn.
    initial begin
        {srst, ext, txn_evt, bus_rst, susp, dma_done, dma_mode, dma_rd, pay_valid} = 9'h100;
        {full0, full1, stall, setup} = '0;
        {txn_ep, pay_data, pay_len} = '0;
        txn = '0;
        failures = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({cur_ep, rd_valid, dma_valid, pay_ready, 1'b0}, 8'h02);
        t_irq();
        t_ext();
        t_codes();
        t_sel();
        t_rst();
        t_buf();
        t_dma();
        conclude();
    end
endmodule
